// >>> bench/erl_links_props.sv
// concurrent checks on the event link block ports
`timescale 1ns/1ps
`include "erl_defs.vh"
module erl_links_props (
  input wire                     CLK,
  input wire                     RESETN,
  input wire                     PSEL,
  input wire                     PENABLE,
  input wire                     PWRITE,
  input wire [`ERL_ADDR_W-1:0]   PADDR,
  input wire                     PREADY,
  input wire                     PSLVERR,
  input wire                     TS_CLEAR_CMD,
  input wire                     INJECT_CMD,
  input wire [1:0]               SER_SYM,
  input wire                     BUFFER_POP_STROBE,
  input wire [`ERL_THRESH_W-1:0] DAC_THRESHOLD,
  input wire [`ERL_NCHAN-1:0]    CHAN_DISABLE,
  input wire                     INJECT_FIRE,
  input wire [`ERL_TS_W-1:0]     TIMESTAMP
);
  reg [6:0] pos;
  reg [2:0] up;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // cycles since the last pop strobe
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pos <= 7'h7f;
      up  <= 3'd0;
    end else begin
      pos <= BUFFER_POP_STROBE ? 7'd1 : (pos != 7'h7f ? pos + 7'd1 : pos);
      up  <= (up != 3'd7) ? up + 3'd1 : up;
    end
  end

  chk_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready missing after access");
  chk_ready_pulse: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
    else $error("ready not a single access pulse");
  chk_err_addr: assert property (PREADY |-> PSLVERR == !(PADDR inside {`ERL_REG_THRESH, `ERL_REG_MASK,
    `ERL_REG_CHARGE_INJECT_SETTING, `ERL_REG_DIAG, `ERL_REG_CTRL, `ERL_REG_STATUS, `ERL_REG_TSTAMP})) else $error("bad slave error");
  chk_dac_write: assert property ($changed(DAC_THRESHOLD) |->
    $past(PSEL && PENABLE && PREADY && PWRITE && PADDR == `ERL_REG_THRESH)) else $error("threshold moved alone");
  chk_mask_write: assert property ($changed(CHAN_DISABLE) |->
    $past(PSEL && PENABLE && PREADY && PWRITE && PADDR == `ERL_REG_MASK, 2)) else $error("mask moved alone");
  chk_hdr_seq: assert property (BUFFER_POP_STROBE |=> SER_SYM == 2'b11 ##1 SER_SYM == 2'b11
    ##1 SER_SYM == 2'b00 ##1 SER_SYM == 2'b00) else $error("bad frame header");
  chk_data_code: assert property (pos >= 7'd5 && pos <= 7'd44 |-> SER_SYM == 2'b01 || SER_SYM == 2'b10)
    else $error("data symbol not coded");
  chk_frame_gap: assert property (BUFFER_POP_STROBE |-> pos >= 7'd45)
    else $error("frame cut short");
  chk_idle_fill: assert property (pos >= 7'd45 && !BUFFER_POP_STROBE |-> SER_SYM == 2'b10)
    else $error("idle fill wrong");
  chk_ts_clear: assert property (TS_CLEAR_CMD |-> ##3 TIMESTAMP == 24'h0)
    else $error("timestamp clear late");
  chk_ts_count: assert property (up == 3'd7 && !$past(TS_CLEAR_CMD, 3) |->
    TIMESTAMP == $past(TIMESTAMP) + 24'h1) else $error("timestamp not counting");
  chk_inject_fire: assert property (INJECT_FIRE |-> $past(INJECT_CMD, 3))
    else $error("inject fired without command");
  cover property (BUFFER_POP_STROBE);
  cover property (PREADY && PSLVERR);
  cover property (INJECT_FIRE);
endmodule

bind erl_links erl_links_props erl_links_props_inst (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PREADY, .PSLVERR, .TS_CLEAR_CMD, .INJECT_CMD, .SER_SYM, .BUFFER_POP_STROBE, .DAC_THRESHOLD,
  .CHAN_DISABLE, .INJECT_FIRE, .TIMESTAMP);

// >>> bench/erl_rx_model.sv
// receiver model for the serial event output
`timescale 1ns/1ps
module erl_rx_model (
  input  wire        clk,
  input  wire        rstn,
  input  wire [1:0]  sym,
  output reg         done,
  output reg  [39:0] pay,
  output reg  [7:0]  bad
);
  reg [5:0]  hist;
  reg [5:0]  cnt;
  reg [39:0] sh;

  // --------------------------------
  // header hunt and bit collection
  // --------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hist <= 6'h0;
      cnt  <= 6'd0;
      done <= 1'b0;
      bad  <= 8'h0;
      sh   <= 40'h0;
      pay  <= 40'h0;
    end else begin
      hist <= {hist[3:0], sym};
      done <= (cnt == 6'd1);
      if (cnt != 6'd0) begin
        sh  <= {sh[38:0], sym == 2'b01};
        cnt <= cnt - 6'd1;
        if (sym != 2'b01 && sym != 2'b10) begin
          bad <= bad + 8'd1;
        end
        if (cnt == 6'd1) begin
          pay <= {sh[38:0], sym == 2'b01};
        end
      end else if ({hist, sym} == 8'hf0) begin
        cnt <= 6'd40;
      end
    end
  end
endmodule

// >>> bench/tb.sv
// self-checking bench for the event link block
`timescale 1ns/1ps
`include "erl_defs.vh"
module tb;
  reg         CLK, RESETN, PSEL, PENABLE, PWRITE, EVT_WRITE, TS_CLEAR_CMD, INJECT_CMD, er;
  reg  [7:0]  PADDR, EVT_HITS;
  reg  [31:0] PWDATA, rd;
  wire [31:0] PRDATA;
  wire        PREADY, PSLVERR, BUFFER_POP_STROBE, INJECT_FIRE, rx_done;
  wire [1:0]  SER_SYM;
  wire [6:0]  DAC_THRESHOLD, INJECT_LEVEL;
  wire [7:0]  CHAN_DISABLE, rx_bad;
  wire [23:0] TIMESTAMP;
  wire [39:0] rx_pay;
  reg  [39:0] expq[$], gotq[$];
  reg  [31:0] msk[0:3] = '{32'h7f, 32'hff, 32'hff, 32'hffff_ffff};
  integer     miscompares = 0, comparisons = 0, cycles = 0, i;

  erl_links erl_links_inst (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .EVT_WRITE, .EVT_HITS, .TS_CLEAR_CMD, .INJECT_CMD, .SER_SYM, .BUFFER_POP_STROBE,
    .DAC_THRESHOLD, .CHAN_DISABLE, .INJECT_LEVEL, .INJECT_FIRE, .TIMESTAMP);
  erl_rx_model erl_rx_model_inst (.clk(CLK), .rstn(RESETN), .sym(SER_SYM), .done(rx_done), .pay(rx_pay),
    .bad(rx_bad));

  // --------------------------------
  // clock, frame capture, timeout
  // --------------------------------
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    if (rx_done) gotq.push_back(rx_pay);
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      test_done;
    end
  end

  task check(input [39:0] seen, input [39:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      k = 0;
      @(posedge CLK);
      while (PREADY !== 1'b1) begin
        @(posedge CLK);
        k = k + 1;
      end
      check(k, 1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
    end
  endtask

  task frames(input integer n);
    integer k;
    begin
      k = 0;
      while (gotq.size() < n && k < 2000) begin
        @(posedge CLK);
        k = k + 1;
      end
      check(gotq.size(), n);
      while (expq.size() > 0 && gotq.size() > 0) check(gotq.pop_front(), expq.pop_front());
    end
  endtask

  // command pulse; the observed output is looked at three edges on
  task cmd(input ts, input en);
    begin
      @(posedge CLK);
      apb(1'b1, `ERL_REG_CHARGE_INJECT_SETTING, {31'h0, en});
      TS_CLEAR_CMD <= ts;
      INJECT_CMD <= !ts;
      @(posedge CLK);
      TS_CLEAR_CMD <= 1'b0;
      INJECT_CMD <= 1'b0;
      repeat (2) @(posedge CLK);
      #1;
      if (ts) check(TIMESTAMP, 24'h0);
      else check(INJECT_FIRE, en);
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    {CLK, RESETN, PSEL, PENABLE, PWRITE, EVT_WRITE, TS_CLEAR_CMD, INJECT_CMD} = 8'h0;
    {PADDR, EVT_HITS, PWDATA} = 48'h0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    check(SER_SYM, 2'b10);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 8'(4 * i), 32'hdead_beef);
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, 32'hdead_beef & msk[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    check({DAC_THRESHOLD, CHAN_DISABLE, INJECT_LEVEL}, {7'h6f, 8'hef, 7'h77});
    $display("register test done");
    apb(1'b1, `ERL_REG_MASK, 32'h0f);
    for (i = 0; i < 18; i = i + 1) begin
      EVT_WRITE <= 1'b1;
      EVT_HITS <= 8'(i * 37);
      @(negedge CLK);
      if (i < 17) expq.push_back({6'h0, 1'b0, i == 16, TIMESTAMP, EVT_HITS & 8'hf0});
      @(posedge CLK);
    end
    EVT_WRITE <= 1'b0;
    apb(1'b0, `ERL_REG_STATUS, 32'h0);
    check({rd[9:8], rd[4:0]}, {2'b11, 5'd16});
    apb(1'b1, `ERL_REG_STATUS, 32'h200);
    apb(1'b0, `ERL_REG_STATUS, 32'h0);
    check(rd[9], 1'b0);
    frames(17);
    apb(1'b0, `ERL_REG_STATUS, 32'h0);
    check(rd[4:0], 5'd0);
    $display("event test done");
    apb(1'b1, `ERL_REG_CTRL, 32'h1);
    expq.push_back({6'h0, 1'b1, 1'b0, 32'hdead_beef});
    frames(1);
    $display("diagnostic test done");
    cmd(1'b1, 1'b0);
    cmd(1'b0, 1'b1);
    cmd(1'b0, 1'b0);
    check(rx_bad, 8'h0);
    $display("command test done");
    test_done;
  end
endmodule

// >>> logic/erl_defs.vh
// constants for the event readout and control link block
`ifndef ERL_DEFS_VH
`define ERL_DEFS_VH

// ----------------------------------------
// widths and depths
// ----------------------------------------
`define ERL_NCHAN        8
`define ERL_TS_W         24
`define ERL_FIFO_DEPTH   16
`define ERL_PTR_W        4
`define ERL_CNT_W        5
`define ERL_REC_W        34
`define ERL_PAY_W        40
`define ERL_BIT_W        6

// ----------------------------------------
// record layout
// ----------------------------------------
`define ERL_REC_HITS     7:0
`define ERL_REC_TS       31:8
`define ERL_REC_NF       32
`define ERL_REC_DIAG     33

// ----------------------------------------
// frame and line code
// ----------------------------------------
`define ERL_HDR_LEN      6'd4
`define ERL_HDR_SYMS     8'hf0
`define ERL_PAY_LEN      6'd40
`define ERL_SYM_ONE      2'b01
`define ERL_SYM_ZERO     2'b10
`define ERL_PAD_W        6

// ----------------------------------------
// timing
// ----------------------------------------
`define ERL_CLK_NS       100
`define ERL_TX_LIMIT_NS  10000
`define ERL_AGE_W        7
`define ERL_AGE_LAST     7'd99

// ----------------------------------------
// apb register map (byte addresses)
// ----------------------------------------
`define ERL_ADDR_W       8
`define ERL_REG_THRESH   8'h00
`define ERL_REG_MASK     8'h04
`define ERL_REG_CHARGE_INJECT_SETTING     8'h08
`define ERL_REG_DIAG     8'h0c
`define ERL_REG_CTRL     8'h10
`define ERL_REG_STATUS   8'h14
`define ERL_REG_TSTAMP   8'h18

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ERL_THRESH_W     7
`define ERL_THRESH_RST   7'h00
`define ERL_MASK_RST     8'h00
`define ERL_CHARGE_INJECT_SETTING_RST     8'h00
`define ERL_CHARGE_INJECT_SETTING_EN      0
`define ERL_CHARGE_INJECT_SETTING_LVL     7:1
`define ERL_DIAG_RST     32'h0000_0000
`define ERL_CTRL_DIAG    0
`define ERL_ST_COUNT     4:0
`define ERL_ST_BUSY      8
`define ERL_ST_OVF       9
`define ERL_ST_NF        10

`endif

// >>> logic/erl_links.v
// event readout framer, time-critical commands and apb register file
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - when an event waits and transmitter idles, start sending the oldest event
// - a pop strobe moves the oldest stored event into the serializer
// - after handing over, the fifo slot is freed for a new event
// - events leave on their own serial output, apart from the control side
// - each event frame completes well inside ten microseconds
// - serial stream is manchester coded, so the receiver recovers its own timing
// - one bit per clock cycle, at the chip clock rate
// - events are pushed out without any request from the receiver
// - each frame opens with a header the receiver cannot confuse with data
// - all frames carry the same number of bits, no trailer
// - control reaches the chip on its own link, independent of event output
// - chip logic runs on the clock the control link delivers
// - timestamp clear may come any cycle, with a fixed delay to the clear
// - inject command may come any cycle, with a fixed delay to firing
// - static configuration words can be written and read over control access
// - threshold register drives the threshold dac
// - mask register has one bit per channel; a set bit disables it
// - charge inject setting register steers the injection circuit
// - diagnostic word can be sent out as an event, triggered by a register write
// - every configuration register is both writable and readable
// - the chip only answers transactions that the outside master starts
// - sixteen events are buffered and released first in, first out
// - the timestamp clear acts synchronously on the rising clock edge
`include "erl_defs.vh"

module erl_links (
  input  wire                         CLK,
  input  wire                         RESETN,
  input  wire                         PSEL,
  input  wire                         PENABLE,
  input  wire                         PWRITE,
  input  wire [`ERL_ADDR_W-1:0]       PADDR,
  input  wire [31:0]                  PWDATA,
  output reg  [31:0]                  PRDATA,
  output reg                          PREADY,
  output reg                          PSLVERR,
  input  wire                         EVT_WRITE,
  input  wire [`ERL_NCHAN-1:0]        EVT_HITS,
  input  wire                         TS_CLEAR_CMD,
  input  wire                         INJECT_CMD,
  output reg  [1:0]                   SER_SYM,
  output reg                          BUFFER_POP_STROBE,
  output reg  [`ERL_THRESH_W-1:0]     DAC_THRESHOLD,
  output reg  [`ERL_NCHAN-1:0]        CHAN_DISABLE,
  output reg  [`ERL_THRESH_W-1:0]     INJECT_LEVEL,
  output reg                          INJECT_FIRE,
  output reg  [`ERL_TS_W-1:0]         TIMESTAMP
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam S_IDLE = 3'b001;
  localparam S_HDR  = 3'b010;
  localparam S_DATA = 3'b100;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // ieee 802.3 manchester: first half, second half
  function [1:0] man_sym;
    input b;
    begin
      man_sym = b ? `ERL_SYM_ONE : `ERL_SYM_ZERO;
    end
  endfunction

  function [`ERL_PTR_W-1:0] ptr_inc;
    input [`ERL_PTR_W-1:0] p;
    begin
      ptr_inc = p + {{(`ERL_PTR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg  [`ERL_REC_W-1:0]   mem [0:`ERL_FIFO_DEPTH-1];
  reg  [`ERL_PTR_W-1:0]   wr_ptr;
  reg  [`ERL_PTR_W-1:0]   rd_ptr;
  reg  [`ERL_CNT_W-1:0]   count;
  reg                     overflow;
  reg  [2:0]              state;
  reg  [`ERL_PAY_W-1:0]   shreg;
  reg  [7:0]              hdr;
  reg  [`ERL_BIT_W-1:0]   bit_cnt;
  reg  [`ERL_AGE_W-1:0]   tx_age;
  reg                     clr_s1;
  reg                     clr_s2;
  reg                     inj_s1;
  reg                     inj_s2;
  reg  [`ERL_NCHAN-1:0]   mask;
  reg  [7:0]              charge_inject_setting;
  reg  [31:0]             diag;
  reg                     diag_pend;
  reg  [31:0]             rd_mux;
  reg                     rd_err;
  wire                    acc;
  wire                    wr_acc;
  wire                    full;
  wire                    near_full;
  wire                    tx_idle;
  wire                    pop;
  wire                    push_evt;
  wire                    push_diag;
  wire                    push;
  wire [`ERL_REC_W-1:0]   push_rec;
  wire                    ovf_clr;
  wire                    tx_overdue;

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // one wait state; the master alone starts transfers
  // ready lasts one cycle, so a setup right after an access starts afresh
  assign acc    = PSEL & PENABLE & PREADY;
  assign wr_acc = acc & PWRITE;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL & PENABLE & ~PREADY) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= rd_err;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // timestamp read only, status takes only a write-one clear of overflow; writing them raises no error
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (PADDR == `ERL_REG_THRESH) begin
      rd_mux[`ERL_THRESH_W-1:0] = DAC_THRESHOLD;
    end else if (PADDR == `ERL_REG_MASK) begin
      rd_mux[`ERL_NCHAN-1:0] = mask;
    end else if (PADDR == `ERL_REG_CHARGE_INJECT_SETTING) begin
      rd_mux[7:0] = charge_inject_setting;
    end else if (PADDR == `ERL_REG_DIAG) begin
      rd_mux = diag;
    end else if (PADDR == `ERL_REG_CTRL) begin
      rd_mux[`ERL_CTRL_DIAG] = diag_pend;
    end else if (PADDR == `ERL_REG_STATUS) begin
      rd_mux[`ERL_ST_COUNT] = count;
      rd_mux[`ERL_ST_BUSY]  = ~tx_idle;
      rd_mux[`ERL_ST_OVF]   = overflow;
      rd_mux[`ERL_ST_NF]    = near_full;
    end else if (PADDR == `ERL_REG_TSTAMP) begin
      rd_mux[`ERL_TS_W-1:0] = TIMESTAMP;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      DAC_THRESHOLD <= `ERL_THRESH_RST;
      mask          <= `ERL_MASK_RST;
      charge_inject_setting          <= `ERL_CHARGE_INJECT_SETTING_RST;
      diag          <= `ERL_DIAG_RST;
    end else if (wr_acc) begin
      // unmapped words are dropped; the slave error flag tells the master
      if (PADDR == `ERL_REG_THRESH) begin
        DAC_THRESHOLD <= PWDATA[`ERL_THRESH_W-1:0];
      end else if (PADDR == `ERL_REG_MASK) begin
        mask <= PWDATA[`ERL_NCHAN-1:0];
      end else if (PADDR == `ERL_REG_CHARGE_INJECT_SETTING) begin
        charge_inject_setting <= PWDATA[7:0];
      end else if (PADDR == `ERL_REG_DIAG) begin
        diag <= PWDATA;
      end
    end
  end

  // registered copies for the front end
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CHAN_DISABLE <= `ERL_MASK_RST;
      INJECT_LEVEL <= `ERL_THRESH_RST;
    end else begin
      CHAN_DISABLE <= mask;
      INJECT_LEVEL <= charge_inject_setting[`ERL_CHARGE_INJECT_SETTING_LVL];
    end
  end

  // ----------------------------------------
  // time-critical commands
  // ----------------------------------------
  // fixed path: two sync flops plus one action flop
  // command pins are levels: a held command acts on every cycle
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
      inj_s1 <= 1'b0;
      inj_s2 <= 1'b0;
    end else begin
      clr_s1 <= TS_CLEAR_CMD;
      clr_s2 <= clr_s1;
      inj_s1 <= INJECT_CMD;
      inj_s2 <= inj_s1;
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TIMESTAMP   <= {`ERL_TS_W{1'b0}};
      INJECT_FIRE <= 1'b0;
    end else begin
      if (clr_s2) begin
        TIMESTAMP <= {`ERL_TS_W{1'b0}};
      end else begin
        TIMESTAMP <= TIMESTAMP + {{(`ERL_TS_W-1){1'b0}}, 1'b1};
      end
      INJECT_FIRE <= inj_s2 & charge_inject_setting[`ERL_CHARGE_INJECT_SETTING_EN];
    end
  end

  // ----------------------------------------
  // diagnostic trigger
  // ----------------------------------------
  // a real event wins the write port; diag waits
  assign push_evt  = EVT_WRITE & ~full;
  assign push_diag = diag_pend & ~EVT_WRITE & ~full;
  assign push      = push_evt | push_diag;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      diag_pend <= 1'b0;
    end else if (wr_acc && PADDR == `ERL_REG_CTRL && PWDATA[`ERL_CTRL_DIAG]) begin
      diag_pend <= 1'b1;
    end else if (push_diag) begin
      diag_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // readout fifo
  // ----------------------------------------
  assign full      = (count == `ERL_FIFO_DEPTH);
  assign near_full = (count == `ERL_FIFO_DEPTH - 1);
  // near-full flag marks the record that takes the last free slot
  assign push_rec  = push_diag ? {1'b1, near_full, diag}
                               : {1'b0, near_full, TIMESTAMP, EVT_HITS & ~mask};
  assign ovf_clr   = wr_acc && PADDR == `ERL_REG_STATUS && PWDATA[`ERL_ST_OVF];

  // no reset on the store: only slots holding a pushed record are ever read
  always @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= push_rec;
    end
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ptr   <= {`ERL_PTR_W{1'b0}};
      rd_ptr   <= {`ERL_PTR_W{1'b0}};
      count    <= {`ERL_CNT_W{1'b0}};
      overflow <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + {{(`ERL_CNT_W-1){1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{(`ERL_CNT_W-1){1'b0}}, 1'b1};
      end
      // lost event is sticky; set beats clear
      if (EVT_WRITE && full) begin
        overflow <= 1'b1;
      end else if (ovf_clr) begin
        overflow <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  // next pop lands on the last data symbol: one idle symbol between frames
  assign tx_idle = (state == S_IDLE);
  assign pop     = tx_idle & (count != {`ERL_CNT_W{1'b0}});

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state             <= S_IDLE;
      shreg             <= {`ERL_PAY_W{1'b0}};
      hdr               <= 8'h00;
      bit_cnt           <= {`ERL_BIT_W{1'b0}};
      BUFFER_POP_STROBE <= 1'b0;
      SER_SYM           <= `ERL_SYM_ZERO;
    end else begin
      BUFFER_POP_STROBE <= pop;
      case (state)
        S_IDLE: begin
          SER_SYM <= man_sym(1'b0);
          if (pop) begin
            shreg   <= {{`ERL_PAD_W{1'b0}}, mem[rd_ptr]};
            hdr     <= `ERL_HDR_SYMS;
            bit_cnt <= {`ERL_BIT_W{1'b0}};
            state   <= S_HDR;
          end
        end
        S_HDR: begin
          // code violations: never legal manchester data
          SER_SYM <= hdr[7:6];
          hdr     <= {hdr[5:0], 2'b00};
          bit_cnt <= bit_cnt + {{(`ERL_BIT_W-1){1'b0}}, 1'b1};
          if (bit_cnt == `ERL_HDR_LEN - 6'd1) begin
            bit_cnt <= {`ERL_BIT_W{1'b0}};
            state   <= S_DATA;
          end
        end
        S_DATA: begin
          // msb first, one bit per clock
          SER_SYM <= man_sym(shreg[`ERL_PAY_W-1]);
          shreg   <= {shreg[`ERL_PAY_W-2:0], 1'b0};
          bit_cnt <= bit_cnt + {{(`ERL_BIT_W-1){1'b0}}, 1'b1};
          if (bit_cnt == `ERL_PAY_LEN - 6'd1) begin
            state <= S_IDLE;
          end
        end
        default: begin
          SER_SYM <= man_sym(1'b0);
          state   <= S_IDLE;
        end
      endcase
      if (tx_overdue) begin
        state <= S_IDLE;
      end
    end
  end

  // ----------------------------------------
  // frame time guard
  // ----------------------------------------
  // age of the frame on the line; a corrupted state still gives the
  // line back within the event time budget
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_age <= {`ERL_AGE_W{1'b0}};
    end else if (tx_idle || tx_overdue) begin
      tx_age <= {`ERL_AGE_W{1'b0}};
    end else begin
      tx_age <= tx_age + {{(`ERL_AGE_W-1){1'b0}}, 1'b1};
    end
  end

  assign tx_overdue = (tx_age == `ERL_AGE_LAST);

endmodule
